// ==== ppc_pkg.sv ====
// constants and types shared by the power control and keyboard pullup block
// What this block does
// - port 3 pins carry no serial or second-timer functions, only interrupt and keyboard roles
// - boost bit clear: all three keyboard pins on port 3 keep normal pullups
// - boost set, select clear: enhanced pullups on 3.0 and 3.3, clock on 3.3
// - boost set, select set: enhanced pullups on 3.0 and 3.2, clock on 3.2
// - reset clears the boost bit and the interrupt select bit
// - power-up holds internal reset roughly 80 to 260 ms without external parts
// - supply dipping below 3 V then recovering gives a fresh internal reset
// - internal reset never drives the reset pin; that pin stays an independent reset input
// - either external interrupt, when set level-sensitive, ends power-down once global and own enables are set
// - setting power-down stops the oscillator and halts all clocked functions
// - power-down keeps register contents and port latches driving
// - power-down drives address latch strobe and program store strobe low
// - level-sensitive wake: pin low restarts oscillator, pin high completes exit
// - after interrupt return, execution resumes after the power-down instruction
// - power fail flag set on supply rise, writable by software, lost below 3 V
// - idle bit enters idle; hardware clears it on interrupt or reset
// - idle and power-down set together: power-down wins
// - control register at 87h; bit 5 reserved; bits 3 and 2 are software flags
// - select clear: key scan drives interrupt a; select set: key scan drives interrupt b
// - key scan interrupt raised whenever any port 1 pin is low
package ppc_pkg;
   localparam int SFR_AW = 8;
   localparam logic [SFR_AW-1:0] POWER_AND_PULLUP_CONTROL_ADDR = 8'h87;
   localparam logic [7:0] POWER_AND_PULLUP_CONTROL_RST = 8'h00;
   localparam logic [7:0] RD_IDLE = 8'h00;
   localparam int B_BOOST = 7;
   localparam int B_KSEL = 6;
   localparam int B_POF = 4;
   localparam int B_GFH = 3;
   localparam int B_GFL = 2;
   localparam int B_PD = 1;
   localparam int B_IDL = 0;
   localparam int P1_W = 8;
   // synchroniser lane positions
   localparam int S_RST = 0;
   localparam int S_VCC = 1;
   localparam int S_P32 = 2;
   localparam int S_P33 = 3;
   localparam int S_P1 = 4;
   localparam int SYNC_W = S_P1 + P1_W;
   // power-up reset hold: least time rounded up to whole cycles
   localparam longint CLK_HZ = 64'd20000000;
   localparam longint POR_MIN_MS = 64'd80;
   localparam longint POR_CYC_DEF = (POR_MIN_MS * CLK_HZ + 64'd999) / 64'd1000;
   localparam int POR_CW = 22;
   typedef enum logic [1:0] {MODE_RUN, MODE_IDLE, MODE_PDOWN, MODE_WAKE} ppc_mode_t;
endpackage : ppc_pkg

// ==== ppc_pwr_if.sv ====
// carrier between the supply supervisor and the control logic
`timescale 1ns/100ps
`default_nettype none
interface ppc_pwr_if;
   logic vcc_ok_s;
   logic por_active;
   logic vcc_rise;
   modport ctl (output vcc_ok_s, input por_active, input vcc_rise);
   modport tmr (input vcc_ok_s, output por_active, output vcc_rise);
endinterface : ppc_pwr_if
`default_nettype wire

// ==== ppc_sync.sv ====
// two-flop synchroniser bank for pin inputs
`timescale 1ns/100ps
`default_nettype none
module ppc_sync
   import ppc_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic [ppc_pkg::SYNC_W-1:0] i_async,
   input wire logic [ppc_pkg::SYNC_W-1:0] i_rst_val,
   output logic [ppc_pkg::SYNC_W-1:0] o_sync
);
   logic [SYNC_W-1:0] meta_q;
   logic [SYNC_W-1:0] sync_q;
   logic [1:0] fill_q;

   genvar g;
   generate
      for (g = 0; g < SYNC_W; g++)
      begin : g_lane
         always_ff @(posedge i_mclk or negedge i_nrst)
         begin
            if (!i_nrst)
            begin
               meta_q[g] <= 1'b0;
               sync_q[g] <= 1'b0;
            end
            else
            begin
               meta_q[g] <= i_async[g];
               sync_q[g] <= meta_q[g];
            end
         end
      end
   endgenerate

   // counts both stages in after reset; a cleared lane would look like a pulled-low pin
   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
         fill_q <= 2'h0;
      else
         fill_q <= {fill_q[0], 1'b1};
   end

   // each lane shows its idle level until the second stage holds a real sample
   assign o_sync = fill_q[1] ? sync_q : i_rst_val;
endmodule : ppc_sync
`default_nettype wire

// ==== ppc_por.sv ====
// supply supervisor: power-up and brown-out internal reset timer
`timescale 1ns/100ps
`default_nettype none
module ppc_por
   import ppc_pkg::*;
#(
   parameter int unsigned POR_CYCLES = 32'(ppc_pkg::POR_CYC_DEF)
)
(
   input wire logic i_mclk,
   input wire logic i_nrst,
   ppc_pwr_if.tmr pwr
);
   logic [POR_CW-1:0] cnt_q;
   logic act_q;
   logic vok_q;
   logic rise_q;

   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         cnt_q <= '0;
         act_q <= 1'b1;
      end
      else if (!pwr.vcc_ok_s)
      begin
         cnt_q <= '0;
         act_q <= 1'b1;
      end
      else if (act_q)
      begin
         if (cnt_q == POR_CW'(POR_CYCLES - 1))
            act_q <= 1'b0;
         else
            cnt_q <= cnt_q + 1'b1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         vok_q <= 1'b0;
         rise_q <= 1'b0;
      end
      else
      begin
         vok_q <= pwr.vcc_ok_s;
         rise_q <= pwr.vcc_ok_s & ~vok_q;
      end
   end

   assign pwr.por_active = act_q;
   assign pwr.vcc_rise = rise_q;
endmodule : ppc_por
`default_nettype wire

// ==== ppc_top.sv ====
// power control register, reset sequencing, idle and power-down, keyboard pullup select
`timescale 1ns/100ps
`default_nettype none
module ppc_top
   import ppc_pkg::*;
#(
   parameter int unsigned POR_CYCLES = 32'(ppc_pkg::POR_CYC_DEF)
)
(
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_ext_rst_pin,
   input wire logic i_vcc_ok,
   input wire logic [ppc_pkg::P1_W-1:0] i_port1_pins,
   input wire logic i_p32_pin,
   input wire logic i_p33_pin,
   input wire logic [ppc_pkg::SFR_AW-1:0] i_sfr_addr,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic i_irq_event,
   input wire logic i_ie_global,
   input wire logic i_ie_a,
   input wire logic i_ie_b,
   input wire logic i_level_a,
   input wire logic i_level_b,
   output logic [7:0] o_sfr_rdata,
   output logic o_int_rst,
   output logic o_pu_enh_p30,
   output logic o_pu_enh_p32,
   output logic o_pu_enh_p33,
   output logic o_kbd_clk_on_p32,
   output logic o_ext_irq_a_n,
   output logic o_ext_irq_b_n,
   output logic o_cpu_halt,
   output logic o_osc_stop,
   output logic o_strobes_low,
   output logic o_port_hold,
   output logic [1:0] o_mode
);
   import ppc_pkg::*;

   // pullup enables for p3.0, p3.2, p3.3 from boost and select
   function automatic logic [2:0] pullup_map(input logic boost, input logic ksel);
      logic [2:0] m;
      m = 3'h0;
      if (boost)
      begin
         m[0] = 1'b1;
         m[1] = ksel;
         m[2] = ~ksel;
      end
      return m;
   endfunction : pullup_map

   // address match for the control register
   function automatic logic power_and_pullup_control_hit(input logic [SFR_AW-1:0] a);
      return a == POWER_AND_PULLUP_CONTROL_ADDR;
   endfunction : power_and_pullup_control_hit

   // ------------------------------------------------------------------
   // pin synchronisers and supply supervisor
   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] pins_rst;
   logic [SYNC_W-1:0] pins_s;
   logic ext_rst_s;
   logic p32_s;
   logic p33_s;
   logic [P1_W-1:0] p1_s;

   always_comb
   begin
      pins_raw = '0;
      pins_raw[S_RST] = i_ext_rst_pin;
      pins_raw[S_VCC] = i_vcc_ok;
      pins_raw[S_P32] = i_p32_pin;
      pins_raw[S_P33] = i_p33_pin;
      pins_raw[S_P1 +: P1_W] = i_port1_pins;
      pins_rst = '0;
      pins_rst[S_P32] = 1'b1;
      pins_rst[S_P33] = 1'b1;
      pins_rst[S_P1 +: P1_W] = '1;
   end

   ppc_sync u_sync (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_async(pins_raw),
      .i_rst_val(pins_rst),
      .o_sync(pins_s)
   );

   assign ext_rst_s = pins_s[S_RST];
   assign p32_s = pins_s[S_P32];
   assign p33_s = pins_s[S_P33];
   assign p1_s = pins_s[S_P1 +: P1_W];

   ppc_pwr_if pwr ();

   assign pwr.vcc_ok_s = pins_s[S_VCC];

   ppc_por #(.POR_CYCLES(POR_CYCLES)) u_por (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .pwr(pwr)
   );

   // ------------------------------------------------------------------
   // internal reset: the pin is only ever an input here, never driven
   logic core_rst_d;
   logic core_rst_q;

   assign core_rst_d = pwr.por_active | ext_rst_s;

   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
         core_rst_q <= 1'b1;
      else
         core_rst_q <= core_rst_d;
   end

   // ------------------------------------------------------------------
   // control register bits
   logic boost_q;
   logic ksel_q;
   logic pof_q;
   logic gfh_q;
   logic gfl_q;
   logic pd_q;
   logic idl_q;
   logic boost_d;
   logic ksel_d;
   logic wr_power_and_pullup_control;
   logic exit_pd;
   ppc_mode_t mode_q;
   ppc_mode_t mode_d;

   assign wr_power_and_pullup_control = i_sfr_wr & power_and_pullup_control_hit(i_sfr_addr);

   always_comb
   begin
      boost_d = boost_q;
      ksel_d = ksel_q;
      if (core_rst_q)
      begin
         boost_d = POWER_AND_PULLUP_CONTROL_RST[B_BOOST];
         ksel_d = POWER_AND_PULLUP_CONTROL_RST[B_KSEL];
      end
      else if (wr_power_and_pullup_control)
      begin
         boost_d = i_sfr_wdata[B_BOOST];
         ksel_d = i_sfr_wdata[B_KSEL];
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         boost_q <= 1'b0;
         ksel_q <= 1'b0;
      end
      else
      begin
         boost_q <= boost_d;
         ksel_q <= ksel_d;
      end
   end

   // general flags: plain storage, reset only; bit 5 has no storage
   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         gfh_q <= 1'b0;
         gfl_q <= 1'b0;
      end
      else if (core_rst_q)
      begin
         gfh_q <= POWER_AND_PULLUP_CONTROL_RST[B_GFH];
         gfl_q <= POWER_AND_PULLUP_CONTROL_RST[B_GFL];
      end
      else if (wr_power_and_pullup_control)
      begin
         gfh_q <= i_sfr_wdata[B_GFH];
         gfl_q <= i_sfr_wdata[B_GFL];
      end
   end

   // power fail flag survives internal resets; supply rise beats a write
   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
         pof_q <= 1'b0;
      else if (pwr.vcc_rise)
         pof_q <= 1'b1;
      else if (!pwr.vcc_ok_s)
         pof_q <= 1'b0;
      else if (wr_power_and_pullup_control)
         pof_q <= i_sfr_wdata[B_POF];
   end

   // idle and power-down bits; a software set wins over a hardware clear
   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         pd_q <= 1'b0;
         idl_q <= 1'b0;
      end
      else if (core_rst_q)
      begin
         pd_q <= POWER_AND_PULLUP_CONTROL_RST[B_PD];
         idl_q <= POWER_AND_PULLUP_CONTROL_RST[B_IDL];
      end
      else if (wr_power_and_pullup_control)
      begin
         pd_q <= i_sfr_wdata[B_PD];
         idl_q <= i_sfr_wdata[B_IDL];
      end
      else
      begin
         if (exit_pd)
            pd_q <= 1'b0;
         if (i_irq_event)
            idl_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // interrupt routing; p3.2 and p3.3 serve only interrupt and keyboard use
   logic kscan_n;
   logic irq_a_n;
   logic irq_b_n;
   logic wake_low;

   assign kscan_n = &p1_s;
   assign irq_a_n = ksel_q ? p32_s : kscan_n;
   assign irq_b_n = ksel_q ? kscan_n : p33_s;
   assign wake_low = i_ie_global & ((i_ie_a & i_level_a & ~irq_a_n) | (i_ie_b & i_level_b & ~irq_b_n));

   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_ext_irq_a_n <= 1'b1;
         o_ext_irq_b_n <= 1'b1;
      end
      else
      begin
         o_ext_irq_a_n <= irq_a_n;
         o_ext_irq_b_n <= irq_b_n;
      end
   end

   // ------------------------------------------------------------------
   // mode sequencer
   always_comb
   begin
      mode_d = mode_q;
      exit_pd = 1'b0;
      if (core_rst_q)
         mode_d = MODE_RUN;
      else
      begin
         unique case (mode_q)
            MODE_RUN:
            begin
               if (wr_power_and_pullup_control && i_sfr_wdata[B_PD])
                  mode_d = MODE_PDOWN;
               else if (wr_power_and_pullup_control && i_sfr_wdata[B_IDL])
                  mode_d = MODE_IDLE;
            end
            MODE_IDLE:
            begin
               if (i_irq_event)
                  mode_d = MODE_RUN;
            end
            MODE_PDOWN:
            begin
               if (wake_low)
                  mode_d = MODE_WAKE;
            end
            MODE_WAKE:
            begin
               if (!wake_low)
               begin
                  mode_d = MODE_RUN;
                  exit_pd = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
         mode_q <= MODE_RUN;
      else
         mode_q <= mode_d;
   end

   // mode outputs follow the next state so the halt lands right after the write
   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_cpu_halt <= 1'b0;
         o_osc_stop <= 1'b0;
         o_strobes_low <= 1'b0;
         o_port_hold <= 1'b0;
         o_mode <= 2'h0;
      end
      else
      begin
         o_cpu_halt <= mode_d != MODE_RUN;
         o_osc_stop <= mode_d == MODE_PDOWN;
         o_strobes_low <= (mode_d == MODE_PDOWN) || (mode_d == MODE_WAKE);
         o_port_hold <= (mode_d == MODE_PDOWN) || (mode_d == MODE_WAKE);
         o_mode <= mode_d;
      end
   end

   // ------------------------------------------------------------------
   // pullup and keyboard pin assignment
   logic [2:0] pu_d;

   assign pu_d = pullup_map(boost_d, ksel_d);

   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_pu_enh_p30 <= 1'b0;
         o_pu_enh_p32 <= 1'b0;
         o_pu_enh_p33 <= 1'b0;
         o_kbd_clk_on_p32 <= 1'b0;
      end
      else
      begin
         o_pu_enh_p30 <= pu_d[0];
         o_pu_enh_p32 <= pu_d[1];
         o_pu_enh_p33 <= pu_d[2];
         o_kbd_clk_on_p32 <= boost_d & ksel_d;
      end
   end

   // ------------------------------------------------------------------
   // register read path, one cycle after the read strobe
   logic [7:0] power_and_pullup_control_val;

   always_comb
   begin
      power_and_pullup_control_val = RD_IDLE;
      power_and_pullup_control_val[B_BOOST] = boost_q;
      power_and_pullup_control_val[B_KSEL] = ksel_q;
      power_and_pullup_control_val[B_POF] = pof_q;
      power_and_pullup_control_val[B_GFH] = gfh_q;
      power_and_pullup_control_val[B_GFL] = gfl_q;
      power_and_pullup_control_val[B_PD] = pd_q;
      power_and_pullup_control_val[B_IDL] = idl_q;
   end

   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
         o_sfr_rdata <= RD_IDLE;
      else if (i_sfr_rd && power_and_pullup_control_hit(i_sfr_addr))
         o_sfr_rdata <= power_and_pullup_control_val;
      else
         o_sfr_rdata <= RD_IDLE;
   end

   // internal reset goes to the core only
   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
         o_int_rst <= 1'b1;
      else
         o_int_rst <= core_rst_q;
   end
endmodule : ppc_top
`default_nettype wire

// ==== ppc_top_monitor.sv ====
// concurrent checks on the ports of the power control block
`timescale 1ns/100ps
`default_nettype none
module ppc_top_monitor
   import ppc_pkg::*;
#(
   parameter int unsigned POR_CYCLES = 32'd20
)
(
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_ext_rst_pin,
   input wire logic i_vcc_ok,
   input wire logic [ppc_pkg::SFR_AW-1:0] i_sfr_addr,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic [7:0] o_sfr_rdata,
   input wire logic o_int_rst,
   input wire logic o_pu_enh_p30,
   input wire logic o_pu_enh_p32,
   input wire logic o_pu_enh_p33,
   input wire logic o_kbd_clk_on_p32,
   input wire logic o_cpu_halt,
   input wire logic o_osc_stop,
   input wire logic o_strobes_low,
   input wire logic o_port_hold,
   input wire logic [1:0] o_mode
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_nrst);
   sequence s_power_and_pullup_control_wr;
      i_sfr_wr && i_sfr_addr == 8'h87 && !o_int_rst;
   endsequence
   sequence s_wake;
      o_mode == 2'd2 ##1 o_mode == 2'd3;
   endsequence
   chk_pullup_pair: assert property (!(o_pu_enh_p32 && o_pu_enh_p33) && ((o_pu_enh_p32 || o_pu_enh_p33) == o_pu_enh_p30))
      else $error("pullup combination not in table");
   chk_clk_pin: assert property (o_kbd_clk_on_p32 == o_pu_enh_p32)
      else $error("keyboard clock pin mismatch");
   chk_boost_write: assert property (s_power_and_pullup_control_wr ##0 i_sfr_wdata[7:6] == 2'b10 |=> o_pu_enh_p30 && o_pu_enh_p33 && !o_pu_enh_p32)
      else $error("boost write without p33 pullups");
   chk_boost_off: assert property (s_power_and_pullup_control_wr ##0 !i_sfr_wdata[7] |=> !o_pu_enh_p30 && !o_pu_enh_p32 && !o_pu_enh_p33)
      else $error("pullups enhanced with boost clear");
   chk_reset_clear: assert property (o_int_rst |=> !o_pu_enh_p30)
      else $error("boost survives reset");
   chk_pd_entry: assert property (s_power_and_pullup_control_wr ##0 i_sfr_wdata[1] |=> o_mode == 2'd2 && o_osc_stop && o_strobes_low && o_port_hold && o_cpu_halt)
      else $error("power-down not entered");
   chk_idle_entry: assert property (s_power_and_pullup_control_wr ##0 i_sfr_wdata[1:0] == 2'b01 |=> o_mode == 2'd1 && o_cpu_halt && !o_osc_stop)
      else $error("idle not entered");
   chk_osc_mode: assert property (o_osc_stop == (o_mode == 2'd2))
      else $error("oscillator stop outside power-down");
   chk_wake_step: assert property (s_wake |-> !o_osc_stop && o_cpu_halt && o_strobes_low)
      else $error("wake step wrong");
   chk_read_idle: assert property (!i_sfr_rd || i_sfr_addr != 8'h87 |=> o_sfr_rdata == 8'h00)
      else $error("read data not idle");
   chk_rsvd_bit: assert property (i_sfr_rd |=> !o_sfr_rdata[5])
      else $error("reserved bit reads set");
   chk_ext_reset: assert property (i_ext_rst_pin |-> ##4 o_int_rst)
      else $error("reset pin ignored");
   chk_brownout: assert property (!i_vcc_ok |-> ##5 o_int_rst)
      else $error("no reset on low supply");
endmodule : ppc_top_monitor
bind ppc_top ppc_top_monitor #(.POR_CYCLES(POR_CYCLES)) ppc_top_monitor_inst (.i_mclk(i_mclk), .i_nrst(i_nrst),
   .i_ext_rst_pin(i_ext_rst_pin), .i_vcc_ok(i_vcc_ok), .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
   .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata), .o_int_rst(o_int_rst),
   .o_pu_enh_p30(o_pu_enh_p30), .o_pu_enh_p32(o_pu_enh_p32), .o_pu_enh_p33(o_pu_enh_p33),
   .o_kbd_clk_on_p32(o_kbd_clk_on_p32), .o_cpu_halt(o_cpu_halt), .o_osc_stop(o_osc_stop),
   .o_strobes_low(o_strobes_low), .o_port_hold(o_port_hold), .o_mode(o_mode));
`default_nettype wire

// ==== ppc_kbd_model.sv ====
// keyboard controller and key matrix seen from the port pins
`timescale 1ns/100ps
`default_nettype none
module ppc_kbd_model
(
   input wire logic i_mclk,
   input wire logic i_clk_on_p32,
   input wire logic i_clk_low,
   input wire logic [7:0] i_keys_n,
   output logic o_p32_pin,
   output logic o_p33_pin,
   output logic [7:0] o_port1_pins
);
   // released lines sit high through the port pullups
   initial
   begin
      o_p32_pin = 1'b1;
      o_p33_pin = 1'b1;
      o_port1_pins = 8'hff;
   end
   always @(negedge i_mclk)
   begin
      o_p32_pin <= !(i_clk_low && i_clk_on_p32);
      o_p33_pin <= !(i_clk_low && !i_clk_on_p32);
      o_port1_pins <= i_keys_n;
   end
endmodule : ppc_kbd_model
`default_nettype wire

// ==== ppc_top_bench.sv ====
// self-checking bench for the power control block
`timescale 1ns/100ps
`default_nettype none
module ppc_top_bench;
   import ppc_pkg::*;
   logic clk = 0, nrst = 0, ext_rst = 0, vcc = 0, wr = 0, rd = 0, irq_ev = 0, ieg = 0, iea = 0, ieb = 0;
   logic lva = 0, lvb = 0, clk_low = 0, rd_pend = 0, p32, p33;
   logic irst, pu30, pu32, pu33, clk32, ia_n, ib_n, halt, oscs, strb, hold;
   logic [7:0] keys_n = 8'hff, p1, addr = 8'h00, wdata = 8'h00, d, rdata;
   logic [1:0] mode, k;
   logic [31:0] st = 32'hfce5;
   logic [7:0] exp_q[$];
   int err_total = 0, comparisons = 0, n;
   initial forever #25 clk = ~clk;
   ppc_top #(.POR_CYCLES(20)) ppc_top_inst (.i_mclk(clk), .i_nrst(nrst), .i_ext_rst_pin(ext_rst), .i_vcc_ok(vcc),
      .i_port1_pins(p1), .i_p32_pin(p32), .i_p33_pin(p33), .i_sfr_addr(addr), .i_sfr_wdata(wdata), .i_sfr_wr(wr),
      .i_sfr_rd(rd), .i_irq_event(irq_ev), .i_ie_global(ieg), .i_ie_a(iea), .i_ie_b(ieb), .i_level_a(lva),
      .i_level_b(lvb), .o_sfr_rdata(rdata), .o_int_rst(irst), .o_pu_enh_p30(pu30), .o_pu_enh_p32(pu32),
      .o_pu_enh_p33(pu33), .o_kbd_clk_on_p32(clk32), .o_ext_irq_a_n(ia_n), .o_ext_irq_b_n(ib_n),
      .o_cpu_halt(halt), .o_osc_stop(oscs), .o_strobes_low(strb), .o_port_hold(hold), .o_mode(mode));
   ppc_kbd_model ppc_kbd_model_inst (.i_mclk(clk), .i_clk_on_p32(clk32), .i_clk_low(clk_low), .i_keys_n(keys_n),
      .o_p32_pin(p32), .o_p33_pin(p33), .o_port1_pins(p1));
   function automatic logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   task close_out;
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : close_out
   task chk(logic [7:0] g, logic [7:0] e);
      comparisons++;
      if (g !== e)
      begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task cyc(int c);
      repeat (c) @(negedge clk);
   endtask : cyc
   task done(string s);
      $display("test %s done", s);
   endtask : done
   task wr_reg(logic [7:0] a, logic [7:0] v);
      addr = a;
      wdata = v;
      wr = 1;
      cyc(1);
      wr = 0;
      cyc(1);
   endtask : wr_reg
   task rd_reg(logic [7:0] a, logic [7:0] e);
      addr = a;
      rd = 1;
      exp_q.push_back(e);
      cyc(1);
      rd = 0;
      cyc(1);
   endtask : rd_reg
   // bounded waits, a timeout ends the run
   task wt_rst(logic v);
      for (n = 0; n < 200 && irst !== v; n++) cyc(1);
      if (irst !== v)
      begin
         err_total++;
         close_out();
      end
   endtask : wt_rst
   task wt_mode(logic [1:0] m);
      for (n = 0; n < 200 && mode !== m; n++) cyc(1);
      if (mode !== m)
      begin
         err_total++;
         close_out();
      end
   endtask : wt_mode
   // read results are compared against the oldest expectation
   always @(posedge clk) rd_pend <= rd;
   always @(negedge clk) if (rd_pend) chk(rdata, exp_q.pop_front());
   initial
   begin
      cyc(10);
      nrst = 1;
      cyc(3);
      vcc = 1;
      wt_rst(0);
      chk(n >= 20 && n <= 30, 1);
      rd_reg(8'h87, 8'h10);
      chk(pu30, 0);
      done("power-up");
      for (int v = 0; v < 4; v++)
      begin
         k = v[1:0];
         st = xs(st);
         d = {k, 6'h00} | (st[7:0] & 8'h1c);
         wr_reg(8'h87, d);
         chk({pu30, pu32, pu33, clk32}, {k[1], k == 2'b11, k == 2'b10, k == 2'b11});
         rd_reg(8'h87, d);
         keys_n = st[15:8] & ~(8'h01 << st[18:16]);
         cyc(6);
         chk({ia_n, ib_n}, {k[0], !k[0]});
         keys_n = 8'hff;
         cyc(4);
      end
      done("pullup table");
      st = xs(st);
      wr_reg(8'h87, 8'h2c);
      wr_reg(8'h8f, 8'hff);
      rd_reg(8'h87, 8'h0c);
      rd_reg(st[7:0] == 8'h87 ? 8'h86 : st[7:0], 8'h00);
      done("map");
      vcc = 0;
      cyc(5);
      chk(irst, 1);
      vcc = 1;
      wt_rst(0);
      rd_reg(8'h87, 8'h10);
      done("brown-out");
      wr_reg(8'h87, 8'h11);
      chk({halt, mode}, 3'b101);
      irq_ev = 1;
      cyc(1);
      irq_ev = 0;
      cyc(1);
      chk({halt, mode}, 3'b000);
      rd_reg(8'h87, 8'h10);
      done("idle");
      for (int s = 0; s < 2; s++)
      begin
         ieg = 0;
         {iea, ieb, lva, lvb} = 4'hf;
         d = {1'b1, s[0], 6'h03};
         wr_reg(8'h87, d);
         chk({halt, oscs, strb, hold, mode}, 6'h3e);
         clk_low = 1;
         cyc(6);
         chk(mode, 2);
         clk_low = 0;
         cyc(4);
         ieg = 1;
         clk_low = 1;
         wt_mode(3);
         chk(oscs, 0);
         clk_low = 0;
         wt_mode(0);
         chk(halt, 0);
         // the wake interrupt is taken, which clears the idle bit written with power-down
         irq_ev = 1;
         cyc(1);
         irq_ev = 0;
         cyc(1);
         rd_reg(8'h87, {d[7:6], 6'h00});
      end
      done("power-down");
      ext_rst = 1;
      wt_rst(1);
      ext_rst = 0;
      wt_rst(0);
      chk({pu30, pu32, pu33}, 0);
      rd_reg(8'h87, 8'h00);
      done("reset pin");
      cyc(3);
      close_out();
   end
endmodule : ppc_top_bench
`default_nettype wire
